//--- verilog/cmp_adc_defs.svh
// Purpose: Constants for the comparator and converter control block
// Assumes: Instruction clock of 25 MHz drives clk
// Notes:   Field codes and counts are named here so the logic holds no bare field codes
`ifndef CMP_ADC_DEFS_SVH
`define CMP_ADC_DEFS_SVH

`define CLK_MHZ            25
`define BIAS_SETTLE_US     256
`define POS_SEL_PA0        2'b00
`define POS_SEL_PA2        2'b01
`define POS_SEL_VREF       2'b10
`define NEG_SEL_PA1        2'b00
`define NEG_SEL_PA3        2'b01
`define NEG_SEL_BANDGAP    2'b10
`define NEG_SEL_VREF       2'b11
`define CKDIV_16           2'b00
`define CKDIV_8            2'b01
`define CKDIV_1            2'b10
`define CKDIV_2            2'b11
`define RES_8              2'b00
`define RES_10             2'b01
`define BITS_8             5'h08
`define BITS_10            5'h0a
`define BITS_12            5'h0c
`define CONV_EXTRA         5'h02
`define CH_LAST_PIN        4'ha
`define CH_QUARTER_VDD     4'hb
`define CH_GROUND          4'hc
`define NUM_PA             5
`define NUM_PB             6
`define RESULT_W           12

`endif

//--- verilog/cmp_adc_pkg.sv
// Purpose: Types shared by the comparator and converter control block
// Assumes: Included after cmp_adc_defs.svh
// Notes:   Holds the sequencer state type only
package cmp_adc_pkg;
   typedef enum logic [1:0] {conv_idle, conv_sample, conv_convert} conv_state_t;
endpackage

//--- verilog/comparator_and_adc_control.sv
// Purpose: Control logic for the voltage comparator and the SAR converter
// Assumes: clk is the instruction clock; analog core answers bit decisions on sar_compare
// Notes:   Analog decisions arrive from another domain and are synchronised first
`timescale 1ns/1ns
`default_nettype none
`include "cmp_adc_defs.svh"

module comparator_and_adc_control
   import cmp_adc_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 rst,
   // Comparator controls
   input  wire logic                 comparator_enable,
   input  wire logic                 halt_mode,
   input  wire logic                 ref_ladder_high_range,
   input  wire logic                 ref_ladder_low_range,
   input  wire logic [3:0]           ref_level_select,
   input  wire logic [1:0]           pos_input_select,
   input  wire logic [1:0]           neg_input_select,
   input  wire logic                 comparator_pad_output_enable,
   input  wire logic                 third_pwm_enable,
   input  wire logic                 third_pwm_level,
   input  wire logic                 comparator_raw,
   output logic                      comparator_power,
   output logic [15:0]               ref_tap_onehot,
   output logic                      ref_range_high,
   output logic                      ref_range_low,
   output logic [3:0]                pos_mux_onehot,
   output logic [3:0]                neg_mux_onehot,
   output logic                      comparator_result,
   output logic                      portb1_out,
   output logic                      portb1_oe,
   // Converter controls
   input  wire logic                 converter_power_on,
   input  wire logic                 start_write,
   input  wire logic                 conversion_irq_enable,
   input  wire logic                 global_irq_enable,
   input  wire logic                 external_ref_select,
   input  wire logic [1:0]           internal_ref_select,
   input  wire logic                 channel_gate,
   input  wire logic [3:0]           channel_select,
   input  wire logic [`NUM_PA-1:0]   porta_analog_mode,
   input  wire logic [`NUM_PB-1:0]   portb_analog_mode,
   input  wire logic [1:0]           converter_clock_divider,
   input  wire logic [1:0]           sample_width_select,
   input  wire logic [1:0]           resolution_select,
   input  wire logic                 sar_compare,
   output logic                      start_bit,
   output logic                      bias_ready,
   output logic                      conversion_done,
   output logic                      converter_irq,
   output logic                      converter_clock,
   output logic                      sample_pulse,
   output logic                      high_ref_external,
   output logic [3:0]                high_ref_internal_onehot,
   output logic [12:0]               channel_onehot,
   output logic [`NUM_PA-1:0]        porta_digital_in_enable,
   output logic [`NUM_PB-1:0]        portb_digital_in_enable,
   output logic [`RESULT_W-1:0]      conversion_result
);

   localparam int BIAS_CYCLES = `BIAS_SETTLE_US * `CLK_MHZ;

   // Divider value for a converter clock code, minus one
   function automatic logic [3:0] div_limit(input logic [1:0] code);
      case (code)
         `CKDIV_16: div_limit = 4'hf;
         `CKDIV_8:  div_limit = 4'h7;
         `CKDIV_1:  div_limit = 4'h0;
         `CKDIV_2:  div_limit = 4'h1;
         default:   div_limit = 4'h0;
      endcase
   endfunction

   // Number of result bits for a resolution code
   function automatic logic [4:0] res_bits(input logic [1:0] code);
      case (code)
         `RES_8:  res_bits = `BITS_8;
         `RES_10: res_bits = `BITS_10;
         default: res_bits = `BITS_12;
      endcase
   endfunction

   // Two-stage synchronisers for analog decisions
   logic cmp_meta, cmp_sync, sar_meta, sar_sync;
   always_ff @(posedge clk) begin
      if (rst) begin
         cmp_meta <= 1'b0;
         cmp_sync <= 1'b0;
         sar_meta <= 1'b0;
         sar_sync <= 1'b0;
      end else begin
         cmp_meta <= comparator_raw;
         cmp_sync <= cmp_meta;
         sar_meta <= sar_compare;
         sar_sync <= sar_meta;
      end
   end

   // Comparator enables and input routing
   logic next_comparator_power;
   logic [15:0] next_ref_tap;
   logic next_rng_h, next_rng_l;
   logic [3:0] next_pos, next_neg;
   logic next_cmp_result, next_pb1_out, next_pb1_oe;
   always_comb begin
      next_comparator_power = comparator_enable & ~halt_mode;
      next_rng_h = ref_ladder_high_range;
      next_rng_l = ref_ladder_low_range;
      // Ladder draws current only when a range is chosen
      next_ref_tap = (next_rng_h | next_rng_l) ? (16'h0001 << ref_level_select) : 16'h0000;
      next_pos = 4'h0;
      case (pos_input_select)
         `POS_SEL_PA0:  next_pos = 4'h1;
         `POS_SEL_PA2:  next_pos = 4'h2;
         `POS_SEL_VREF: next_pos = 4'h4;
         default:       next_pos = 4'h0; // Undefined code: nothing routed
      endcase
      case (neg_input_select)
         `NEG_SEL_PA1:     next_neg = 4'h1;
         `NEG_SEL_PA3:     next_neg = 4'h2;
         `NEG_SEL_BANDGAP: next_neg = 4'h4;
         default:          next_neg = 4'h8;
      endcase
      if (!next_comparator_power) begin
         next_pos = 4'h0;
         next_neg = 4'h0;
      end
      // A powered-down comparator reports low
      next_cmp_result = cmp_sync & comparator_power;
      // Pad output has priority over the PWM on the shared pin
      if (comparator_pad_output_enable) begin
         next_pb1_out = next_cmp_result;
         next_pb1_oe  = 1'b1;
      end else begin
         next_pb1_out = third_pwm_level & third_pwm_enable;
         next_pb1_oe  = third_pwm_enable;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         comparator_power  <= 1'b0;
         ref_tap_onehot    <= 16'h0000;
         ref_range_high    <= 1'b0;
         ref_range_low     <= 1'b0;
         pos_mux_onehot    <= 4'h0;
         neg_mux_onehot    <= 4'h0;
         comparator_result <= 1'b0;
         portb1_out        <= 1'b0;
         portb1_oe         <= 1'b0;
      end else begin
         comparator_power  <= next_comparator_power;
         ref_tap_onehot    <= next_ref_tap;
         ref_range_high    <= next_rng_h;
         ref_range_low     <= next_rng_l;
         pos_mux_onehot    <= next_pos;
         neg_mux_onehot    <= next_neg;
         comparator_result <= next_cmp_result;
         portb1_out        <= next_pb1_out;
         portb1_oe         <= next_pb1_oe;
      end
   end

   // Static converter routing
   logic next_href_ext;
   logic [3:0] next_href_int;
   logic [12:0] next_chan;
   always_comb begin
      next_href_ext = external_ref_select;
      next_href_int = external_ref_select ? 4'h0 : (4'h1 << internal_ref_select);
      next_chan = 13'h0000;
      // Codes above ground are unconnected
      if (channel_gate && channel_select <= `CH_GROUND) begin
         next_chan = 13'h0001 << channel_select;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         high_ref_external        <= 1'b0;
         high_ref_internal_onehot <= 4'h0;
         channel_onehot           <= 13'h0000;
         porta_digital_in_enable  <= '1;
         portb_digital_in_enable  <= '1;
      end else begin
         high_ref_external        <= next_href_ext;
         high_ref_internal_onehot <= next_href_int;
         channel_onehot           <= next_chan;
         porta_digital_in_enable  <= ~porta_analog_mode;
         portb_digital_in_enable  <= ~portb_analog_mode;
      end
   end

   // Converter clock divider and bias settling counter
   conv_state_t state, next_state;
   logic [3:0] div_cnt, next_div_cnt;
   logic next_conv_clk, tick;
   logic [13:0] bias_cnt, next_bias_cnt;
   logic next_bias_ready;
   always_comb begin
      tick = (div_cnt >= div_limit(converter_clock_divider));
      next_div_cnt = tick ? 4'h0 : div_cnt + 4'h1;
      // High for the first half period; divide by one stays high, being clk itself
      next_conv_clk = converter_power_on & (div_cnt <= (div_limit(converter_clock_divider) >> 1));
      // Restart at launch so the sampling pulse spans whole periods
      if (!converter_power_on || (state == conv_idle && start_bit)) begin
         next_div_cnt = 4'h0;
      end
      next_bias_cnt = bias_cnt;
      next_bias_ready = bias_ready;
      // Settling status only; software is still expected to wait
      if (!converter_power_on) begin
         next_bias_cnt = 14'h0000;
         next_bias_ready = 1'b0;
      end else if (bias_cnt == 14'(BIAS_CYCLES - 1)) begin
         next_bias_ready = 1'b1;
      end else begin
         next_bias_cnt = bias_cnt + 14'h0001;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         div_cnt         <= 4'h0;
         converter_clock <= 1'b0;
         bias_cnt        <= 14'h0000;
         bias_ready      <= 1'b0;
      end else begin
         div_cnt         <= next_div_cnt;
         converter_clock <= next_conv_clk;
         bias_cnt        <= next_bias_cnt;
         bias_ready      <= next_bias_ready;
      end
   end

   // Conversion sequencer, advancing once per converter clock period
   logic [3:0] phase_cnt, next_phase_cnt;
   logic [4:0] bit_cnt, next_bit_cnt;
   logic [`RESULT_W-1:0] next_result;
   logic next_start_bit, next_done, next_irq, next_sample;
   always_comb begin
      next_state = state;
      next_phase_cnt = phase_cnt;
      next_bit_cnt = bit_cnt;
      next_result = conversion_result;
      next_start_bit = start_bit;
      next_done = conversion_done;
      next_sample = 1'b0;
      case (state)
         conv_idle: begin
            // Start is only taken while idle, so a busy write is dropped
            if (start_write && converter_power_on) begin
               next_start_bit = 1'b1;
            end
            if (start_bit) begin
               next_start_bit = 1'b0;
               next_done = 1'b0;
               next_state = conv_sample;
               next_phase_cnt = (4'h1 << sample_width_select) - 4'h1;
               next_result = '0;
            end
         end
         conv_sample: begin
            next_sample = 1'b1;
            if (tick) begin
               if (phase_cnt == 4'h0) begin
                  next_state = conv_convert;
                  // Resolution bits plus two overhead periods
                  next_bit_cnt = res_bits(resolution_select) + `CONV_EXTRA;
               end else begin
                  next_phase_cnt = phase_cnt - 4'h1;
               end
            end
         end
         conv_convert: begin
            if (tick) begin
               // Bit decisions land MSB first; overhead periods shift nothing
               if (bit_cnt > `CONV_EXTRA) begin
                  next_result = {conversion_result[`RESULT_W-2:0], sar_sync};
               end
               if (bit_cnt == 5'h01) begin
                  next_state = conv_idle;
                  next_done = 1'b1;
               end
               next_bit_cnt = bit_cnt - 5'h01;
            end
         end
         default: next_state = conv_idle;
      endcase
      if (!converter_power_on) begin
         next_state = conv_idle;
         next_start_bit = 1'b0;
      end
      // Interrupt pulse on the done rising edge only
      next_irq = next_done & ~conversion_done & conversion_irq_enable
                 & global_irq_enable;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state             <= conv_idle;
         phase_cnt         <= 4'h0;
         bit_cnt           <= 5'h00;
         conversion_result <= '0;
         start_bit         <= 1'b0;
         conversion_done   <= 1'b0;
         converter_irq     <= 1'b0;
         sample_pulse      <= 1'b0;
      end else begin
         state             <= next_state;
         phase_cnt         <= next_phase_cnt;
         bit_cnt           <= next_bit_cnt;
         conversion_result <= next_result;
         start_bit         <= next_start_bit;
         conversion_done   <= next_done;
         converter_irq     <= next_irq;
         sample_pulse      <= next_sample;
      end
   end

endmodule
`default_nettype wire

//--- verification/comparator_and_adc_control_asserts.sv
// Purpose: Port checks for the comparator and converter control block
// Assumes: Bound to comparator_and_adc_control, single clock domain
// Notes:   Every check is idle while rst is high
`timescale 1ns/1ns
`default_nettype none
`include "cmp_adc_defs.svh"
module cmp_adc_chk (
   input wire logic               clk,
   input wire logic               rst,
   input wire logic               comparator_enable,
   input wire logic               halt_mode,
   input wire logic               comparator_pad_output_enable,
   input wire logic               third_pwm_enable,
   input wire logic               third_pwm_level,
   input wire logic               comparator_power,
   input wire logic               comparator_result,
   input wire logic               portb1_out,
   input wire logic               portb1_oe,
   input wire logic               start_bit,
   input wire logic               conversion_done,
   input wire logic               converter_irq,
   input wire logic               converter_power_on,
   input wire logic               conversion_irq_enable,
   input wire logic               global_irq_enable,
   input wire logic               channel_gate,
   input wire logic [12:0]        channel_onehot,
   input wire logic [`NUM_PA-1:0] porta_analog_mode,
   input wire logic [`NUM_PA-1:0] porta_digital_in_enable
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Comparator power and pad routing
   a_cmp_off_idle: assert property (!comparator_enable |=> !comparator_power)
      else $error("comparator powered while disabled");
   a_halt_forces_off: assert property (halt_mode |=> !comparator_power)
      else $error("comparator powered in halt");
   a_pad_follows: assert property (!$past(rst) && $past(comparator_pad_output_enable)
      && $stable(comparator_result) |-> portb1_oe && portb1_out == comparator_result)
      else $error("pad does not mirror comparator");
   a_pwm_passes: assert property (!$past(rst) && !$past(comparator_pad_output_enable)
      |-> portb1_oe == $past(third_pwm_enable)
      && portb1_out == $past(third_pwm_enable & third_pwm_level))
      else $error("pwm path wrong on shared pin");
   // Converter handshake; a slow divider gives at most 352 cycles plus sync
   a_start_once: assert property (start_bit |=> !start_bit && !conversion_done)
      else $error("start bit not self clearing");
   a_conv_bounded: assert property (start_bit && converter_power_on |-> ##[2:420] conversion_done)
      else $error("conversion never finished");
   a_irq_on_done: assert property ($rose(conversion_done) && conversion_irq_enable
      && global_irq_enable |-> ##[0:1] converter_irq ##1 !converter_irq)
      else $error("missing or long interrupt pulse");
   // Static routing registered one cycle
   a_gate_blocks: assert property (!$past(rst) && !$past(channel_gate) |-> channel_onehot == 13'h0)
      else $error("channel connected with gate low");
   a_analog_pins: assert property (!$past(rst)
      |-> porta_digital_in_enable == ~$past(porta_analog_mode))
      else $error("digital input not cut on analog pin");
   c_done: cover property ($rose(conversion_done));
   c_irq: cover property (converter_irq);
   c_pad: cover property (comparator_pad_output_enable && comparator_result);
endmodule
`default_nettype wire

//--- verification/cmp_adc_analog_model.sv
// Purpose: Analog core stand-in answering comparator and SAR decisions
// Assumes: Levels set by the bench per scenario
// Notes:   Outputs churn when the core is off, so stale levels never pass
`timescale 1ns/1ns
`default_nettype none
module cmp_adc_analog_model (
   input  wire logic clk,
   input  wire logic comparator_power,
   input  wire logic conversion_done,
   input  wire logic converter_power_on,
   input  wire logic cmp_level,
   input  wire logic sar_level,
   output var logic  comparator_raw,
   output var logic  sar_compare
);
   logic churn = 1'b0;
   // Toggle pattern for an unpowered core
   always @(posedge clk) begin
      churn <= ~churn;
   end
   // Comparator live only when powered
   assign comparator_raw = comparator_power ? cmp_level : churn;
   // Decisions live while powered, so the sync latency never eats a first bit
   assign sar_compare = converter_power_on ? sar_level : churn;
endmodule
`default_nettype wire

//--- verification/comparator_and_adc_control_tb.sv
// Purpose: Self-checking bench for comparator and converter control
// Assumes: 25 MHz clk, synchronous active-high reset
// Notes:   Expectations come from an in-bench model of the field codes
`timescale 1ns/1ns
`default_nettype none
module comparator_and_adc_control_tb;
   logic        clk, rst, comparator_enable, halt_mode, ref_ladder_high_range;
   logic        ref_ladder_low_range, comparator_pad_output_enable, third_pwm_enable;
   logic        third_pwm_level, comparator_raw, converter_power_on, start_write;
   logic        conversion_irq_enable, global_irq_enable, external_ref_select;
   logic        channel_gate, sar_compare, cmp_level, sar_level;
   logic [3:0]  ref_level_select, channel_select, pos_mux_onehot, neg_mux_onehot;
   logic [3:0]  high_ref_internal_onehot;
   logic [1:0]  pos_input_select, neg_input_select, internal_ref_select;
   logic [1:0]  converter_clock_divider, sample_width_select, resolution_select;
   logic [4:0]  porta_analog_mode, porta_digital_in_enable;
   logic [5:0]  portb_analog_mode, portb_digital_in_enable;
   logic        comparator_power, ref_range_high, ref_range_low, comparator_result;
   logic        portb1_out, portb1_oe, start_bit, bias_ready, conversion_done;
   logic        converter_irq, converter_clock, sample_pulse, high_ref_external;
   logic [15:0] ref_tap_onehot;
   logic [12:0] channel_onehot;
   logic [11:0] conversion_result;
   int          err_total = 0, check_count = 0, cycles = 0;

   comparator_and_adc_control i_comparator_and_adc_control (.*);
   cmp_adc_analog_model i_cmp_adc_analog_model (.clk(clk), .comparator_power(comparator_power),
      .conversion_done(conversion_done), .converter_power_on(converter_power_on),
      .cmp_level(cmp_level), .sar_level(sar_level), .comparator_raw(comparator_raw),
      .sar_compare(sar_compare));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic wrap_up();
      if (err_total == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Hang guard, well above the worst conversion sweep
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 60000) begin
         err_total++;
         wrap_up();
      end
   end

   // One conversion; a second start is thrown in while busy
   task automatic convert(input int dv, input int sw, input int rs, input logic lvl);
      int div, e, n, w, irqs, ck;
      div = (dv == 0) ? 16 : (dv == 1) ? 8 : (dv == 2) ? 1 : 2;
      e = ((1 << sw) + ((rs == 0) ? 8 : (rs == 1) ? 10 : 12) + 2) * div;
      n = 0;
      w = 0;
      irqs = 0;
      ck = 0;
      @(posedge clk);
      converter_clock_divider <= dv[1:0];
      sample_width_select <= sw[1:0];
      resolution_select <= rs[1:0];
      sar_level <= lvl;
      conversion_irq_enable <= 1'($urandom);
      global_irq_enable <= 1'($urandom);
      @(posedge clk);
      start_write <= 1'b1;
      @(posedge clk);
      start_write <= 1'b0;
      @(negedge clk);
      chk("start_bit", 1, start_bit);
      // Done of the last run still stands here; it drops at launch
      do begin
         @(posedge clk);
         start_write <= (n == 3);
         @(negedge clk);
         n++;
         w += (sample_pulse === 1'b1);
         ck += (converter_clock === 1'b1 && n > 1);
         irqs += (converter_irq === 1'b1);
      end while (conversion_done !== 1'b1 && n < 1000);
      @(negedge clk);
      irqs += (converter_irq === 1'b1);
      chk("sample_width", (1 << sw) * div, w);
      chk("conv_time", e + 1, n);
      chk("conv_clock", (div == 1) ? e : e / 2, ck);
      chk("result", lvl ? (1 << ((rs == 0) ? 8 : (rs == 1) ? 10 : 12)) - 1 : 0,
          conversion_result);
      chk("irq", conversion_irq_enable & global_irq_enable, irqs);
      repeat (3) @(negedge clk);
      chk("done_hold", 1, conversion_done);
   endtask

   initial begin
      logic on;
      int settle;
      void'($urandom(32'h9d5dddd8));
      {rst, comparator_enable, halt_mode, ref_ladder_high_range, ref_ladder_low_range} = 5'h10;
      {comparator_pad_output_enable, third_pwm_enable, third_pwm_level, cmp_level} = 4'h0;
      {converter_power_on, start_write, conversion_irq_enable, global_irq_enable} = 4'h0;
      {external_ref_select, channel_gate, sar_level, ref_level_select} = 7'h00;
      {channel_select, pos_input_select, neg_input_select, internal_ref_select} = 10'h000;
      {converter_clock_divider, sample_width_select, resolution_select} = 6'h00;
      {porta_analog_mode, portb_analog_mode} = 11'h000;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      // Comparator, ladder, pad and routing sweep
      for (int i = 0; i < 32; i++) begin
         @(posedge clk);
         comparator_enable <= !(i[4] && i[2]);
         halt_mode <= i[4] && i[3] && !i[2];
         pos_input_select <= i[1:0];
         neg_input_select <= i[3:2];
         ref_ladder_high_range <= i[2];
         ref_ladder_low_range <= i[3] && !(i[4] && !i[2]);
         ref_level_select <= i[3:0] ^ 4'h5;
         cmp_level <= 1'($urandom);
         comparator_pad_output_enable <= i[0];
         third_pwm_enable <= 1'($urandom);
         third_pwm_level <= 1'($urandom);
         channel_gate <= i[4];
         channel_select <= i[3:0];
         external_ref_select <= i[4] && i[0];
         internal_ref_select <= i[2:1];
         porta_analog_mode <= 5'($urandom);
         portb_analog_mode <= 6'($urandom);
         repeat (5) @(posedge clk);
         @(negedge clk);
         on = comparator_enable & ~halt_mode;
         chk("cmp_power", on, comparator_power);
         chk("pos_mux", (on && i % 4 != 3) ? 1 << (i % 4) : 0, pos_mux_onehot);
         chk("neg_mux", on ? 1 << (i / 4 % 4) : 0, neg_mux_onehot);
         chk("ref_tap", (ref_ladder_high_range | ref_ladder_low_range) ?
             1 << ref_level_select : 0, ref_tap_onehot);
         chk("ref_range", {ref_ladder_high_range, ref_ladder_low_range},
             {ref_range_high, ref_range_low});
         chk("cmp_result", on & cmp_level, comparator_result);
         chk("pb1", comparator_pad_output_enable ? {1'b1, on & cmp_level} :
             {third_pwm_enable, third_pwm_enable & third_pwm_level},
             {portb1_oe, portb1_out});
         chk("channel", (i[4] && i % 16 <= 12) ? 1 << (i % 16) : 0, channel_onehot);
         chk("high_ref", external_ref_select ? 5'h10 : 1 << internal_ref_select,
             {high_ref_external, high_ref_internal_onehot});
         chk("dig_in", 11'(~{porta_analog_mode, portb_analog_mode}),
             {porta_digital_in_enable, portb_digital_in_enable});
      end
      // Start with the converter unpowered is refused
      @(posedge clk);
      start_write <= 1'b1;
      channel_gate <= 1'b1;
      channel_select <= 4'h0;
      porta_analog_mode <= 5'h01;
      @(posedge clk);
      start_write <= 1'b0;
      @(negedge clk);
      chk("start_off", 0, start_bit);
      @(posedge clk);
      converter_power_on <= 1'b1;
      for (settle = 0; settle < 7000 && bias_ready !== 1'b1; settle++) @(negedge clk);
      // Settling spans 256 us of the 25 MHz clock, seen one negedge late
      chk("bias_wait", 256 * 25 + 1, settle);
      // Every divider, sample width and resolution code
      for (int dv = 0; dv < 4; dv++) begin
         for (int sw = 0; sw < 4; sw++) begin
            for (int rs = 0; rs < 4; rs++) begin
               convert(dv, sw, rs, 1'((dv + sw + rs) % 2));
            end
         end
      end
      wrap_up();
   end
endmodule
bind comparator_and_adc_control cmp_adc_chk i_cmp_adc_chk (.*);
`default_nettype wire
